// ===== inc/hpkc_pkg.sv
// Package for the keypad-driven host power sequencer.
// Assumes a single 250 MHz system clock; all times become tick counts here.
package hpkc_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_HZ      = 250_000_000;
  // One tick is 1/32 second so the pulse width setting counts ticks directly.
  localparam int unsigned TICKS_PER_S = 32;
  localparam int unsigned TICK_CYC    = CLK_HZ / TICKS_PER_S;

  // Key hold and pulse times, expressed in ms and in ticks.
  localparam int unsigned ON_HOLD_MS   = 250;
  localparam int unsigned LONG_HOLD_MS = 4000;
  localparam int unsigned EXTRA_MAX_MS = 5000;
  localparam int unsigned RST_PULSE_MS = 1000;
  localparam int unsigned ON_HOLD_TK   = ON_HOLD_MS * TICKS_PER_S / 1000;
  localparam int unsigned LONG_HOLD_TK = LONG_HOLD_MS * TICKS_PER_S / 1000;
  localparam int unsigned EXTRA_MAX_TK = EXTRA_MAX_MS * TICKS_PER_S / 1000;
  localparam int unsigned RST_PULSE_TK = RST_PULSE_MS * TICKS_PER_S / 1000;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_PULSE  = 12'h004;
  localparam logic [11:0] ADDR_SENSE  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;

  // Control register field positions.
  localparam int unsigned CTRL_PWR_OFF_EN = 0;
  localparam int unsigned CTRL_PWR_ON_EN  = 1;
  localparam int unsigned CTRL_RESET_EN   = 2;
  localparam int unsigned CTRL_BLANK_EN   = 3;
  localparam int unsigned CTRL_AUTO_POL   = 4;
  localparam int unsigned CTRL_PWR_INV    = 5;
  localparam int unsigned CTRL_RST_INV    = 6;

  localparam logic [6:0] CTRL_RESET_VAL  = 7'h00;
  localparam logic [7:0] PULSE_RESET_VAL = 8'h20;
  localparam logic [0:0] SENSE_RESET_VAL = 1'h0;
  localparam logic [7:0] SENSE_CONN      = 8'h00;

  localparam int unsigned NUM_GPIO = 5;
  localparam int unsigned GPIO_SENSE = 1;
  localparam int unsigned GPIO_PWR   = 2;
  localparam int unsigned GPIO_RST   = 3;

  typedef enum {
    HPKC_IDLE,
    HPKC_HOLD_ON,
    HPKC_HOLD_OFF,
    HPKC_HOLD_RST,
    HPKC_PULSE_ON,
    HPKC_PULSE_OFF,
    HPKC_PULSE_EXT,
    HPKC_PULSE_RST,
    HPKC_WAIT_REL
  } hpkc_state_e;

  typedef struct packed {
    logic rst_inv;
    logic pwr_inv;
    logic auto_pol;
    logic blank_en;
    logic reset_en;
    logic pwr_on_en;
    logic pwr_off_en;
  } hpkc_ctrl_s;

  typedef struct packed {
    logic [NUM_GPIO-1:0] o;
    logic [NUM_GPIO-1:0] oe;
  } hpkc_gpio_s;

endpackage : hpkc_pkg

// ===== design/hpkc_top.sv
// Keypad-driven host power sequencer with an APB register slave.
// Assumes keys and sense inputs are already synchronous and debounced.
//
// What this block does
// - Power switch pin floats except while acting; driven level follows power polarity.
// - Reset pin floats except while resetting host; driven level follows reset polarity.
// - Power-on enabled, sense low, Enter held 0.25 s: pulse power switch.
// - Hard-off enabled, sense high, Cancel held 4 s: pulse power switch.
// - Holding Cancel past the pulse extends drive by at most 5 s.
// - Hard reset enabled, sense high, Enter held 4 s: reset pulse 1 s.
// - Right after the host reset pulse, the device reboots itself.
// - Power on, hard off and hard reset each have their own enable.
// - With blanking on, display is blanked whenever host sense is low.
// - Pulse width setting counts 1/32 s, so 16 gives half a second.
// - Sense source 0 selects the power connector supply-sense input.
// - Sense can instead come from general-purpose pin 1.
// - Five general-purpose pins; pin 2 power switch, pin 3 reset.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

module hpkc_top
  import hpkc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = hpkc_pkg::TICK_CYC
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [11:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic                          key_enter_i,
  input  wire logic                          key_cancel_i,
  input  wire logic                          conn_sense_i,
  input  wire logic [hpkc_pkg::NUM_GPIO-1:0] gpio_i,
  output logic      [hpkc_pkg::NUM_GPIO-1:0] gpio_o,
  output logic      [hpkc_pkg::NUM_GPIO-1:0] gpio_oe_o,
  output logic                               blank_when_host_down_o,
  output logic                               self_reboot_o
);
  import hpkc_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  hpkc_ctrl_s  ctrl_q;
  logic [7:0]  pulse_q;
  logic [0:0]  sense_sel_q;
  logic        pol_pwr_q;
  logic        pol_rst_q;
  logic        pol_lat_q;
  logic        host_on;
  hpkc_state_e state_q;

  wire apb_setup  = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i;
  wire addr_ok    = (paddr_i == ADDR_CTRL) | (paddr_i == ADDR_PULSE) |
                    (paddr_i == ADDR_SENSE) | (paddr_i == ADDR_STATUS);

  // No wait state: ready is raised in the first access cycle.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~addr_ok;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q      <= hpkc_ctrl_s'(CTRL_RESET_VAL);
      pulse_q     <= PULSE_RESET_VAL;
      sense_sel_q <= SENSE_RESET_VAL;
    end else if (apb_access & pready_o & pwrite_i) begin
      case (paddr_i)
        ADDR_CTRL:  ctrl_q <= hpkc_ctrl_s'(pwdata_i[6:0]);
        ADDR_PULSE: begin
          if (pwdata_i[7:0] != 8'h00) begin
            pulse_q <= pwdata_i[7:0];
          end
        end
        // Any nonzero low byte moves sense to the legacy pin.
        ADDR_SENSE: sense_sel_q <= (pwdata_i[7:0] != SENSE_CONN) ? 1'b1 : 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup & ~pwrite_i) begin
      case (paddr_i)
        ADDR_CTRL:   prdata_o <= {25'h0, ctrl_q};
        ADDR_PULSE:  prdata_o <= {24'h0, pulse_q};
        ADDR_SENSE:  prdata_o <= {31'h0, sense_sel_q};
        ADDR_STATUS: prdata_o <= {24'h0, pol_rst_q, pol_pwr_q, pol_lat_q, host_on, 4'(state_q)};
        default:     prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Host sense and polarity
  // ****************************************************************
  assign host_on = sense_sel_q[0] ? gpio_i[GPIO_SENSE] : conn_sense_i;

  // Auto polarity samples the idle level of each pin while nothing drives it:
  // the switch inputs idle at their inactive level, so drive the opposite.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pol_pwr_q <= 1'b0;
      pol_rst_q <= 1'b0;
      pol_lat_q <= 1'b0;
    end else if (state_q == HPKC_IDLE) begin
      pol_pwr_q <= ctrl_q.auto_pol ? ~gpio_i[GPIO_PWR] : ctrl_q.pwr_inv;
      pol_rst_q <= ctrl_q.auto_pol ? ~gpio_i[GPIO_RST] : ctrl_q.rst_inv;
      pol_lat_q <= ctrl_q.auto_pol;
    end
  end

  // ****************************************************************
  // Tick divider
  // ****************************************************************
  logic [31:0] div_q;
  logic        tick_q;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (div_q >= 32'(TICK_CYCLES - 1)) begin
      div_q  <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [15:0] tk_q;
  wire         hold_on_go  = ctrl_q.pwr_on_en & ~host_on & key_enter_i;
  wire         hold_off_go = ctrl_q.pwr_off_en & host_on & key_cancel_i;
  wire         hold_rst_go = ctrl_q.reset_en & host_on & key_enter_i;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= HPKC_IDLE;
      tk_q    <= 16'h0;
    end else begin
      case (state_q)
        HPKC_IDLE: begin
          tk_q <= 16'h0;
          if (hold_on_go) begin
            state_q <= HPKC_HOLD_ON;
          end else if (hold_off_go) begin
            state_q <= HPKC_HOLD_OFF;
          end else if (hold_rst_go) begin
            state_q <= HPKC_HOLD_RST;
          end
        end
        HPKC_HOLD_ON: begin
          if (!key_enter_i) begin
            state_q <= HPKC_IDLE;
          end else if (tick_q && tk_q >= 16'(ON_HOLD_TK - 1)) begin
            state_q <= HPKC_PULSE_ON;
            tk_q    <= 16'h0;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_HOLD_OFF: begin
          if (!key_cancel_i) begin
            state_q <= HPKC_IDLE;
          end else if (tick_q && tk_q >= 16'(LONG_HOLD_TK - 1)) begin
            state_q <= HPKC_PULSE_OFF;
            tk_q    <= 16'h0;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_HOLD_RST: begin
          if (!key_enter_i) begin
            state_q <= HPKC_IDLE;
          end else if (tick_q && tk_q >= 16'(LONG_HOLD_TK - 1)) begin
            state_q <= HPKC_PULSE_RST;
            tk_q    <= 16'h0;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_PULSE_ON: begin
          if (tick_q && tk_q >= 16'(pulse_q - 8'h1)) begin
            state_q <= HPKC_WAIT_REL;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_PULSE_OFF: begin
          if (tick_q && tk_q >= 16'(pulse_q - 8'h1)) begin
            tk_q    <= 16'h0;
            state_q <= key_cancel_i ? HPKC_PULSE_EXT : HPKC_WAIT_REL;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_PULSE_EXT: begin
          if (!key_cancel_i || (tick_q && tk_q >= 16'(EXTRA_MAX_TK - 1))) begin
            state_q <= HPKC_WAIT_REL;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        HPKC_PULSE_RST: begin
          if (tick_q && tk_q >= 16'(RST_PULSE_TK - 1)) begin
            state_q <= HPKC_WAIT_REL;
          end else if (tick_q) begin
            tk_q <= tk_q + 16'h1;
          end
        end
        // Wait for both keys up so one press never triggers twice.
        HPKC_WAIT_REL: begin
          if (!key_enter_i && !key_cancel_i) begin
            state_q <= HPKC_IDLE;
          end
        end
        default: state_q <= HPKC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pins and outputs
  // ****************************************************************
  wire pwr_act = (state_q == HPKC_PULSE_ON) | (state_q == HPKC_PULSE_OFF) | (state_q == HPKC_PULSE_EXT);
  wire rst_act = (state_q == HPKC_PULSE_RST);
  wire rst_end = rst_act & tick_q & (tk_q >= 16'(RST_PULSE_TK - 1));

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gpio_o                 <= '0;
      gpio_oe_o              <= '0;
      blank_when_host_down_o <= 1'b0;
      self_reboot_o          <= 1'b0;
    end else begin
      gpio_o                 <= '0;
      gpio_oe_o              <= '0;
      gpio_o[GPIO_PWR]       <= pol_pwr_q;
      gpio_oe_o[GPIO_PWR]    <= pwr_act;
      gpio_o[GPIO_RST]       <= pol_rst_q;
      gpio_oe_o[GPIO_RST]    <= rst_act;
      blank_when_host_down_o <= ctrl_q.blank_en & ~host_on;
      // Reboot is asked for in the first cycle after the reset pin is let go, never while it is still driven.
      self_reboot_o          <= gpio_oe_o[GPIO_RST] & ~rst_act;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_hold_cancel;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_q == HPKC_HOLD_ON && !key_enter_i) |=> state_q == HPKC_IDLE ##1 !gpio_oe_o[GPIO_PWR];
  endproperty
  a_hold_cancel: assert property (p_hold_cancel) else $error("early release did not cancel");

  property p_pwr_oe;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      gpio_oe_o[GPIO_PWR] |-> $past(pwr_act);
  endproperty
  a_pwr_oe: assert property (p_pwr_oe) else $error("power pin driven while idle");

  property p_rst_oe;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(rst_act) |=> gpio_oe_o[GPIO_RST] && gpio_o[GPIO_RST] == pol_rst_q;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("reset pin not driven");

  property p_reboot;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      rst_end |=> ##1 self_reboot_o && !gpio_oe_o[GPIO_RST] ##1 !self_reboot_o;
  endproperty
  a_reboot: assert property (p_reboot) else $error("no reboot after reset pulse");

  property p_on_needs_en;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_q == HPKC_IDLE ##1 state_q == HPKC_HOLD_ON) |-> $past(ctrl_q.pwr_on_en && !host_on);
  endproperty
  a_on_needs_en: assert property (p_on_needs_en) else $error("power on started while disabled");

  property p_blank;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (ctrl_q.blank_en && !host_on) |=> blank_when_host_down_o;
  endproperty
  a_blank: assert property (p_blank) else $error("display not blanked");

  property p_sense_pin;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      sense_sel_q[0] |=> blank_when_host_down_o == $past(ctrl_q.blank_en && !gpio_i[GPIO_SENSE]);
  endproperty
  a_sense_pin: assert property (p_sense_pin) else $error("wrong sense source");

  property p_ext_release;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_q == HPKC_PULSE_EXT && !key_cancel_i) |=> state_q == HPKC_WAIT_REL;
  endproperty
  a_ext_release: assert property (p_ext_release) else $error("extension ran past key release");

  property p_pwr_level;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      gpio_oe_o[GPIO_PWR] |-> gpio_o[GPIO_PWR] == pol_pwr_q;
  endproperty
  a_pwr_level: assert property (p_pwr_level) else $error("power pin driven at wrong level");

  property p_rst_only;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      gpio_oe_o[GPIO_RST] |-> $past(rst_act);
  endproperty
  a_rst_only: assert property (p_rst_only) else $error("reset pin driven while idle");

  property p_off_needs_en;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_q == HPKC_IDLE ##1 state_q == HPKC_HOLD_OFF) |-> $past(ctrl_q.pwr_off_en && host_on);
  endproperty
  a_off_needs_en: assert property (p_off_needs_en) else $error("hard off started while disabled");

  property p_rst_needs_en;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (state_q == HPKC_IDLE ##1 state_q == HPKC_HOLD_RST) |-> $past(ctrl_q.reset_en && host_on);
  endproperty
  a_rst_needs_en: assert property (p_rst_needs_en) else $error("hard reset started while disabled");

  property p_spare_pins;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !gpio_oe_o[0] && !gpio_oe_o[GPIO_SENSE] && !gpio_oe_o[NUM_GPIO-1];
  endproperty
  a_spare_pins: assert property (p_spare_pins) else $error("spare pin driven");

endmodule : hpkc_top

// ===== bench/hpkc_host_model.sv
// Behavioural model of the host motherboard's power switch and reset inputs.
// Assumes the sequencer drives gpio_o/gpio_oe_o and reads pin levels on gpio_i.
`timescale 1ns/10ps

module hpkc_host_model
  import hpkc_pkg::*;
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic [hpkc_pkg::NUM_GPIO-1:0] gpio_o_i,
  input  wire logic [hpkc_pkg::NUM_GPIO-1:0] gpio_oe_i,
  input  wire logic                          swap_i,
  output logic      [hpkc_pkg::NUM_GPIO-1:0] gpio_o,
  output logic                               sense_o
);
  // ****************************************************************
  // Pin levels
  // ****************************************************************
  logic host_on_q;
  logic press_q;
  logic tog_q;
  logic pin2;
  logic pin3;

  // Switch and reset inputs are pulled up on the board, so a released pin reads high.
  assign pin2 = gpio_oe_i[GPIO_PWR] ? gpio_o_i[GPIO_PWR] : 1'b1;
  assign pin3 = gpio_oe_i[GPIO_RST] ? gpio_o_i[GPIO_RST] : 1'b1;
  // Pin 0 floats, so it shows a changing pattern rather than a stale level.
  assign gpio_o  = {1'b1, pin3, pin2, host_on_q ^ swap_i, tog_q};
  assign sense_o = host_on_q;

  // ****************************************************************
  // Host power state
  // ****************************************************************
  // A press of the power switch toggles the host when the button is let go.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_on_q <= 1'b0;
      press_q   <= 1'b0;
      tog_q     <= 1'b0;
    end else begin
      tog_q   <= ~tog_q;
      press_q <= ~pin2;
      if (press_q && pin2) begin
        host_on_q <= ~host_on_q;
      end
    end
  end
endmodule : hpkc_host_model

// ===== bench/tb.sv
// Self-checking testbench of the keypad host power sequencer.
// Assumes the host model on the pins and a short tick of 4 clocks.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module tb;
  import hpkc_pkg::*;
  localparam int T = 4;
  logic                sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic                key_enter = 0, key_cancel = 0, swap = 0, conn_sense, blank, reboot, pready, pslverr, err;
  logic [11:0]         paddr = 0;
  logic [31:0]         pwdata = 0, prdata, rd;
  logic [NUM_GPIO-1:0] gpio_in, gpio_out, gpio_oe, o, oe;
  int                  n_errors = 0, samples_checked = 0, w, len;

  always #2 sys_clk = ~sys_clk;

  hpkc_top #(.TICK_CYCLES(T)) uut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .key_enter_i(key_enter), .key_cancel_i(key_cancel), .conn_sense_i(conn_sense),
    .gpio_i(gpio_in), .gpio_o(gpio_out), .gpio_oe_o(gpio_oe), .blank_when_host_down_o(blank),
    .self_reboot_o(reboot));

  hpkc_host_model host (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .gpio_o_i(gpio_out), .gpio_oe_i(gpio_oe),
    .swap_i(swap), .gpio_o(gpio_in), .sense_o(conn_sense));

  // ****************************************************************
  // Bus and pin helpers
  // ****************************************************************
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // Waits for the drive of one pin, snapshots the pins, then times the drive.
  task pulse(input int idx, input int maxw);
    w = 0;
    len = 0;
    while (gpio_oe[idx] !== 1'b1 && w < maxw) begin
      @(posedge sys_clk);
      w++;
    end
    o = gpio_out;
    oe = gpio_oe;
    while (gpio_oe[idx] === 1'b1 && len < 4000) begin
      @(posedge sys_clk);
      len++;
    end
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    apb(0, ADDR_CTRL, 0);   `CHK("ctrl reset", 32'(CTRL_RESET_VAL), rd)
    apb(0, ADDR_PULSE, 0);  `CHK("pulse reset", 32'(PULSE_RESET_VAL), rd)
    apb(0, ADDR_SENSE, 0);  `CHK("sense reset", 32'(SENSE_RESET_VAL), rd)
    apb(0, 12'h010, 0);     `CHK("unmapped err", 1'b1, err)
    apb(1, ADDR_PULSE, 0);
    apb(0, ADDR_PULSE, 0);  `CHK("pulse zero ignored", 32'h20, rd)
    apb(1, ADDR_PULSE, 16);
    apb(0, ADDR_PULSE, 0);  `CHK("pulse half second", 32'h10, rd)
    apb(1, ADDR_CTRL, 32'h60);
    apb(0, ADDR_STATUS, 0); `CHK("status drive levels", 32'h0000_00c0, rd)
  endtask : t_regs

  task t_power_on;
    apb(1, ADDR_CTRL, 0);
    key_enter <= 1;
    pulse(GPIO_PWR, 80);    `CHK("power on disabled", 0, len)
    key_enter <= 0;
    apb(1, ADDR_CTRL, 32'h02);
    key_enter <= 1;
    repeat (16) @(posedge sys_clk);
    key_enter <= 0;
    pulse(GPIO_PWR, 60);    `CHK("early release", 0, len)
    key_enter <= 1;
    pulse(GPIO_PWR, 200);
    key_enter <= 0;
    `CHK("on hold time", 1'b1, w >= 8*T-T && w <= 8*T+2*T+2)
    `CHK("on drive level", 1'b0, o[GPIO_PWR])
    `CHK("on pulse width", 1'b1, len >= 16*T-T && len <= 16*T+2*T)
    repeat (4) @(posedge sys_clk);
    `CHK("host on", 1'b1, conn_sense)
  endtask : t_power_on

  task t_reset;
    int n;
    apb(1, ADDR_CTRL, 32'h06);
    key_enter <= 1;
    pulse(GPIO_RST, 700);
    `CHK("reset hold time", 1'b1, w >= 128*T-T && w <= 128*T+2*T+2)
    `CHK("reset enables", 5'h08, oe)
    `CHK("reset level", 1'b0, o[GPIO_RST])
    `CHK("reset width", 1'b1, len >= 32*T-T && len <= 32*T+2*T)
    n = 0;
    while (reboot !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("self reboot", 1'b1, reboot)
    key_enter <= 0;
    `CHK("host kept on", 1'b1, conn_sense)
  endtask : t_reset

  task t_hard_off;
    // Power invert is set, so only automatic polarity can yield a low drive here.
    apb(1, ADDR_CTRL, 32'h31);
    key_cancel <= 1;
    pulse(GPIO_PWR, 700);
    `CHK("off hold time", 1'b1, w >= 128*T-T && w <= 128*T+2*T+2)
    `CHK("auto polarity", 1'b0, o[GPIO_PWR])
    `CHK("off max drive", 1'b1, len >= 176*T-T && len <= 176*T+2*T)
    key_cancel <= 0;
    repeat (4) @(posedge sys_clk);
    `CHK("host off", 1'b0, conn_sense)
  endtask : t_hard_off

  task t_blank;
    apb(1, ADDR_CTRL, 32'h08);
    repeat (3) @(posedge sys_clk);
    `CHK("blank host off", 1'b1, blank)
    swap <= 1;
    apb(1, ADDR_SENSE, 1);
    repeat (3) @(posedge sys_clk);
    `CHK("legacy sense", 1'b0, blank)
    apb(1, ADDR_SENSE, 0);
    repeat (3) @(posedge sys_clk);
    `CHK("connector sense", 1'b1, blank)
  endtask : t_blank

  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task finish_test;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    t_regs;
    t_power_on;
    t_reset;
    t_hard_off;
    t_blank;
    finish_test;
  end

  // The whole sequence needs about 2200 clocks; this allows ample margin.
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_errors++;
    finish_test;
  end
endmodule : tb
